// file: sac_top.sv
// control, timing and result logic of the 10-bit successive-approximation converter
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "sac_defines.svh"

module sac_top (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // wishbone slave
    input  wire sac_pkg::sac_wb_req_t wb_req,
    output logic                     wb_ack_o,
    output logic [31:0]              wb_dat_o,
    // system state
    input  wire logic                standby_req,
    input  wire logic                clock_divider_option,
    // analog front end
    input  wire logic                comparator_i,
    output sac_pkg::sac_analog_t     analog_o,
    // status
    output logic                     conversion_done_irq,
    output logic                     converter_busy_flag,
    output logic                     end_of_conversion_flag
);

    typedef struct packed {
        logic                ack;
        logic [31:0]         rdata;
        logic [7:0]          conv_control_one;
        logic [7:0]          conv_control_two;
        sac_pkg::sac_phase_t phase;
        logic [11:0]         total_cnt;
        logic [11:0]         step_cnt;
        logic [3:0]          bit_idx;
        logic [9:0]          sar;
        logic [9:0]          result;
        logic                eoc;
        logic                busy;
        logic                irq;
        logic                comp_meta;
        logic                comp_sync;
        sac_pkg::sac_analog_t ana;
    } sac_state_t;

    sac_state_t s_q;
    sac_state_t s_d;

    // conversion length for a time code and divider setting
    function automatic logic [11:0] sac_cycles(input logic [2:0] code, input logic div);
        logic [11:0] n;
        n = `SAC_CYC_39;
        if (!div)
        begin
            unique case (code)
                3'h2:    n = `SAC_CYC_78;
                3'h3:    n = `SAC_CYC_156;
                3'h4:    n = `SAC_CYC_312;
                3'h5:    n = `SAC_CYC_624;
                3'h6:    n = `SAC_CYC_1248;
                default: n = `SAC_CYC_39;
            endcase
        end
        else
        begin
            unique case (code)
                3'h2:    n = `SAC_CYC_156;
                3'h3:    n = `SAC_CYC_312;
                3'h4:    n = `SAC_CYC_624;
                3'h5:    n = `SAC_CYC_1248;
                3'h6:    n = `SAC_CYC_2096;
                default: n = `SAC_CYC_39;
            endcase
        end
        return n;
    endfunction

    logic        access;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [5:0]  reg_idx;
    logic [1:0]  new_mode;
    logic [11:0] conv_len;
    logic [11:0] trial_len;
    logic [11:0] sample_len;
    logic        launch;
    logic        abort;
    logic [9:0]  trial_mask;
    logic [9:0]  kept_code;
    logic [31:0] read_mux;

    always_comb
    begin
        s_d = s_q;
        s_d.irq = 1'b0;
        // start bit never holds beyond one cycle
        s_d.conv_control_one[`SAC_C1_START] = 1'b0;

        // comparator is asynchronous to this clock
        s_d.comp_meta = comparator_i;
        s_d.comp_sync = s_q.comp_meta;

        // bus decode; write and read side effects land on the acknowledging edge
        access    = wb_req.cyc & wb_req.stb;
        reg_idx   = wb_req.adr[7:2];
        wr_strobe = access & s_q.ack & wb_req.we & wb_req.sel[0];
        rd_strobe = access & s_q.ack & ~wb_req.we;
        s_d.ack   = access & ~s_q.ack;

        // timing for the current settings
        conv_len   = sac_cycles(s_q.conv_control_two[`SAC_C2_TIME_HI:`SAC_C2_TIME_LO],
                                clock_divider_option);
        // comparator sync takes two clocks, so a trial must span three or more
        trial_len  = conv_len / `SAC_TRIAL_DIV;
        // sampling takes whatever the ten trials leave over
        sample_len = 12'(conv_len - 12'(trial_len * `SAC_TRIALS));

        // register read multiplexer
        read_mux = 32'h0000_0000;
        unique case (reg_idx)
            `SAC_IDX_CTRL_ONE: read_mux[7:0] = s_q.conv_control_one;
            // top two bits carry no storage
            `SAC_IDX_CTRL_TWO: read_mux[7:0] = {2'b00, s_q.conv_control_two[5:0]};
            `SAC_IDX_RES_HIGH: read_mux[7:0] = s_q.result[9:2];
            `SAC_IDX_RES_LOW:
            begin
                read_mux[`SAC_R2_BIT1] = s_q.result[1];
                read_mux[`SAC_R2_BIT0] = s_q.result[0];
                read_mux[`SAC_R2_EOC]  = s_q.eoc;
                read_mux[`SAC_R2_BUSY] = s_q.busy;
                // low nibble has no meaning; reads as zero
                read_mux[3:0]          = 4'h0;
            end
            default:           read_mux = 32'h0000_0000;
        endcase
        if (access & ~s_q.ack)
        begin
            s_d.rdata = read_mux;
        end

        // reading the high result byte clears the end flag
        if (rd_strobe && reg_idx == `SAC_IDX_RES_HIGH)
        begin
            s_d.eoc = 1'b0;
        end

        // control register writes; result registers take no writes
        launch   = 1'b0;
        abort    = 1'b0;
        new_mode = wb_req.dat[`SAC_C1_MODE_HI:`SAC_C1_MODE_LO];
        if (wr_strobe && reg_idx == `SAC_IDX_CTRL_ONE)
        begin
            s_d.conv_control_one = wb_req.dat[7:0];
            if (new_mode == `SAC_MODE_OFF && s_q.phase != sac_pkg::SAC_IDLE)
            begin
                abort = 1'b1;
            end
            // start only from idle and in a running mode; mode 10 starts nothing, but unlike off it aborts nothing
            if (wb_req.dat[`SAC_C1_START] && s_q.phase == sac_pkg::SAC_IDLE &&
                (new_mode == `SAC_MODE_SINGLE || new_mode == `SAC_MODE_REPEAT))
            begin
                launch = 1'b1;
            end
        end
        if (wr_strobe && reg_idx == `SAC_IDX_CTRL_TWO)
        begin
            s_d.conv_control_two = {2'b00, wb_req.dat[5:0]};
        end

        // successive approximation sequence
        trial_mask = 10'(10'h001 << s_q.bit_idx);
        kept_code  = s_q.comp_sync ? s_q.sar : (s_q.sar & ~trial_mask);
        unique case (s_q.phase)
            sac_pkg::SAC_IDLE:
            begin
                s_d.busy = 1'b0;
            end
            sac_pkg::SAC_SAMPLE:
            begin
                s_d.total_cnt = 12'(s_q.total_cnt - 12'd1);
                s_d.step_cnt  = 12'(s_q.step_cnt - 12'd1);
                if (s_q.step_cnt == 12'd0)
                begin
                    s_d.phase    = sac_pkg::SAC_TRIAL;
                    s_d.sar      = `SAC_MSB_CODE;
                    s_d.bit_idx  = `SAC_MSB_INDEX;
                    s_d.step_cnt = 12'(trial_len - 12'd1);
                end
            end
            sac_pkg::SAC_TRIAL:
            begin
                s_d.total_cnt = 12'(s_q.total_cnt - 12'd1);
                s_d.step_cnt  = 12'(s_q.step_cnt - 12'd1);
                if (s_q.step_cnt == 12'd0)
                begin
                    if (s_q.total_cnt == 12'd0)
                    begin
                        // result, flag and interrupt in one edge
                        s_d.result = kept_code;
                        s_d.eoc    = 1'b1;
                        s_d.irq    = 1'b1;
                        if (s_q.conv_control_one[`SAC_C1_MODE_HI:`SAC_C1_MODE_LO] == `SAC_MODE_REPEAT)
                        begin
                            // next conversion begins at once; busy stays high
                            // end flag stays set; a read of the high result byte or standby clears it
                            s_d.phase     = sac_pkg::SAC_SAMPLE;
                            s_d.total_cnt = 12'(conv_len - 12'd1);
                            s_d.step_cnt  = 12'(sample_len - 12'd1);
                            s_d.sar       = 10'h000;
                        end
                        else
                        begin
                            // single shot: busy drops on the completion edge itself
                            s_d.phase = sac_pkg::SAC_IDLE;
                            s_d.busy  = 1'b0;
                        end
                    end
                    else
                    begin
                        s_d.sar      = kept_code | 10'(trial_mask >> 1);
                        s_d.bit_idx  = 4'(s_q.bit_idx - 4'd1);
                        s_d.step_cnt = 12'(trial_len - 12'd1);
                    end
                end
            end
            default:
            begin
                // unused state code falls back to idle
                s_d.phase = sac_pkg::SAC_IDLE;
                s_d.busy  = 1'b0;
            end
        endcase

        // abort discards the partial code
        if (abort)
        begin
            s_d.phase = sac_pkg::SAC_IDLE;
            s_d.busy  = 1'b0;
            s_d.sar   = 10'h000;
            s_d.irq   = 1'b0;
        end

        if (launch)
        begin
            s_d.phase     = sac_pkg::SAC_SAMPLE;
            s_d.total_cnt = 12'(conv_len - 12'd1);
            s_d.step_cnt  = 12'(sample_len - 12'd1);
            s_d.sar       = 10'h000;
            s_d.busy      = 1'b1;
            // old result kept until this conversion completes
            s_d.eoc       = 1'b0;
        end

        // standby: both control registers back to reset and held there
        // the stored result is lost, as is any conversion in flight
        if (standby_req)
        begin
            s_d.conv_control_one = `SAC_C1_RESET;
            s_d.conv_control_two = `SAC_C2_RESET;
            s_d.phase            = sac_pkg::SAC_IDLE;
            s_d.busy             = 1'b0;
            s_d.eoc              = 1'b0;
            s_d.irq              = 1'b0;
            s_d.sar              = 10'h000;
            s_d.result           = `SAC_RES_RESET;
        end

        // registered front-end controls
        s_d.ana.dac_code             = s_d.sar;
        s_d.ana.channel_select       = s_d.conv_control_one[`SAC_C1_CHAN_HI:`SAC_C1_CHAN_LO];
        s_d.ana.analog_input_disable = s_d.conv_control_one[`SAC_C1_INDIS];
        s_d.ana.sample_hold          = (s_d.phase == sac_pkg::SAC_SAMPLE);
        s_d.ana.ladder_connect       = s_d.conv_control_two[`SAC_C2_LADDER] | s_d.busy;
    end

    // single register for all block state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.ack                      <= 1'b0;
            s_q.rdata                    <= 32'h0000_0000;
            s_q.conv_control_one         <= `SAC_C1_RESET;
            s_q.conv_control_two         <= `SAC_C2_RESET;
            s_q.phase                    <= sac_pkg::SAC_IDLE;
            s_q.total_cnt                <= 12'h000;
            s_q.step_cnt                 <= 12'h000;
            s_q.bit_idx                  <= 4'h0;
            s_q.sar                      <= 10'h000;
            s_q.result                   <= `SAC_RES_RESET;
            s_q.eoc                      <= 1'b0;
            s_q.busy                     <= 1'b0;
            s_q.irq                      <= 1'b0;
            s_q.comp_meta                <= 1'b0;
            s_q.comp_sync                <= 1'b0;
            s_q.ana.dac_code             <= 10'h000;
            s_q.ana.channel_select       <= 4'h0;
            s_q.ana.sample_hold          <= 1'b0;
            s_q.ana.ladder_connect       <= 1'b0;
            // input buffers start disabled, as control one resets with bit 4 set
            s_q.ana.analog_input_disable <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o               = s_q.ack;
    assign wb_dat_o               = s_q.rdata;
    assign analog_o               = s_q.ana;
    assign conversion_done_irq    = s_q.irq;
    assign converter_busy_flag    = s_q.busy;
    assign end_of_conversion_flag = s_q.eoc;

endmodule

// file: sac_defines.svh
// register offsets, field positions, reset values and cycle counts of the converter control
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// register indices; byte address is four times the index
`define SAC_IDX_CTRL_ONE   6'h0E
`define SAC_IDX_CTRL_TWO   6'h0F
`define SAC_IDX_RES_LOW    6'h26
`define SAC_IDX_RES_HIGH   6'h27

// conv_control_one fields
`define SAC_C1_START       7
`define SAC_C1_MODE_HI     6
`define SAC_C1_MODE_LO     5
`define SAC_C1_INDIS       4
`define SAC_C1_CHAN_HI     3
`define SAC_C1_CHAN_LO     0

// conv_control_two fields
`define SAC_C2_TOP_HI      7
`define SAC_C2_TOP_LO      6
`define SAC_C2_LADDER      5
`define SAC_C2_TIME_HI     3
`define SAC_C2_TIME_LO     1

// result_low_flags fields
`define SAC_R2_BIT1        7
`define SAC_R2_BIT0        6
`define SAC_R2_EOC         5
`define SAC_R2_BUSY        4

// reset values
`define SAC_C1_RESET       8'h10
`define SAC_C2_RESET       8'h10
`define SAC_RES_RESET      10'h000

// operating mode codes
`define SAC_MODE_OFF       2'b00
`define SAC_MODE_SINGLE    2'b01
`define SAC_MODE_REPEAT    2'b11

// conversion lengths in oscillator clocks
`define SAC_CYC_39         12'd39
`define SAC_CYC_78         12'd78
`define SAC_CYC_156        12'd156
`define SAC_CYC_312        12'd312
`define SAC_CYC_624        12'd624
`define SAC_CYC_1248       12'd1248
`define SAC_CYC_2096       12'd2096

// ten trials plus sampling; trial length is the conversion length over thirteen
`define SAC_TRIALS         12'd10
`define SAC_TRIAL_DIV      12'd13
`define SAC_MSB_CODE       10'h200
`define SAC_MSB_INDEX      4'd9

`endif

// file: sac_pkg.sv
// types shared by the converter control logic
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_TRIAL
    } sac_phase_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sac_wb_req_t;

    typedef struct packed {
        logic [9:0] dac_code;
        logic [3:0] channel_select;
        logic       sample_hold;
        logic       ladder_connect;
        logic       analog_input_disable;
    } sac_analog_t;

endpackage

// file: sac_top_checker.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sac_top_checker (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    // bus
    input wire sac_pkg::sac_wb_req_t wb_req,
    input wire logic                 wb_ack_o,
    // state and status
    input wire logic                 standby_req,
    input wire sac_pkg::sac_analog_t analog_o,
    input wire logic                 conversion_done_irq,
    input wire logic                 converter_busy_flag,
    input wire logic                 end_of_conversion_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    irq_eoc_a: assert property (conversion_done_irq |-> end_of_conversion_flag)
        else $error("irq without end flag");
    standby_clear_a: assert property (standby_req |=> !converter_busy_flag && !end_of_conversion_flag)
        else $error("flags not cleared in standby");
    ladder_busy_a: assert property (converter_busy_flag |-> analog_o.ladder_connect)
        else $error("ladder off while busy");
    busy_start_a: assert property ($rose(converter_busy_flag) |-> !end_of_conversion_flag && analog_o.sample_hold)
        else $error("start without eoc clear or sampling");
    irq_busy_a: assert property (conversion_done_irq |-> $past(converter_busy_flag))
        else $error("completion without conversion");
    rd_clear_a: assert property (wb_ack_o && !wb_req.we && wb_req.adr == 8'h9C
        |=> !end_of_conversion_flag || conversion_done_irq)
        else $error("high byte read left eoc set");
    res_write_a: assert property (wb_ack_o && wb_req.we && wb_req.adr[7:4] == 4'h9
        |=> $stable(end_of_conversion_flag) || conversion_done_irq)
        else $error("result write changed eoc");
endmodule

bind sac_top sac_top_checker i_sac_top_checker (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_ack_o(wb_ack_o), .standby_req(standby_req), .analog_o(analog_o),
    .conversion_done_irq(conversion_done_irq), .converter_busy_flag(converter_busy_flag),
    .end_of_conversion_flag(end_of_conversion_flag));

// file: sac_afe_model.sv
// analog front end model: per-channel levels compared against the ladder code
`timescale 1ns/1ps
module sac_afe_model (
    // clock
    input wire logic                 ref_clk,
    // analog control and levels
    input wire sac_pkg::sac_analog_t analog_i,
    input wire logic [9:0]           level [16],
    // comparator
    output logic                     comparator_o
);
    logic idle_q = 1'b0;

    always_ff @(posedge ref_clk)
        idle_q <= ~idle_q;

    // ladder off: comparison meaningless, output wanders
    assign comparator_o = analog_i.ladder_connect ?
        (level[analog_i.channel_select] >= analog_i.dac_code) : idle_q;
endmodule

// file: tb_sac_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sac_top;
    logic                 ref_clk;
    logic                 rst_n;
    logic                 standby_req;
    logic                 div_opt;
    logic                 comparator_i;
    logic                 wb_ack_o;
    logic [31:0]          wb_dat_o;
    logic                 irq;
    logic                 busy;
    logic                 eoc;
    logic [9:0]           lev [16];
    sac_pkg::sac_wb_req_t wb_req;
    sac_pkg::sac_analog_t analog_o;
    int                   error_cnt = 0;
    int                   cmp_count = 0;

    sac_top i_sac_top (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .standby_req(standby_req), .clock_divider_option(div_opt),
        .comparator_i(comparator_i), .analog_o(analog_o), .conversion_done_irq(irq),
        .converter_busy_flag(busy), .end_of_conversion_flag(eoc));
    sac_afe_model i_sac_afe_model (.ref_clk(ref_clk), .analog_i(analog_o), .level(lev),
        .comparator_o(comparator_i));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h000000, wd}};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o[7:0];
        chk("ack", 12'h001, {11'h000, wb_ack_o});
        wb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, adr, d, x);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [7:0] d);
        bus(1'b0, adr, 8'h00, d);
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    function automatic int cyc_of(input logic dv, input logic [2:0] c);
        case (c)
            3'b010: return dv ? 156 : 78;
            3'b011: return dv ? 312 : 156;
            3'b100: return dv ? 624 : 312;
            3'b101: return dv ? 1248 : 624;
            3'b110: return dv ? 2096 : 1248;
            default: return 39;
        endcase
    endfunction

    task automatic run_conv(input logic [3:0] ch, input logic [2:0] code, output int n);
        wr(8'h3C, {4'b0001, code, 1'b0});
        wr(8'h38, {4'b1010, ch});
        chk("start", {6'h00, 2'b10, ch}, {6'h00, busy, eoc, analog_o.channel_select});
        wait_irq(n);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(8'h38, d);
        chk("c1_rst", 8'h10, d);
        rd(8'h3C, d);
        chk("c2_rst", 8'h10, d & 8'h3F);
        wr(8'h98, 8'hFF);
        wr(8'h9C, 8'hFF);
        rd(8'h9C, d);
        chk("hi_rst", 8'h00, d);
        rd(8'h98, d);
        chk("lo_rst", 8'h00, d & 8'hF0);
        rd(8'hF0, d);
        wr(8'h38, 8'hC4);
        chk("rsv_mode", 1'b0, busy);
        $display("reset test done");
    endtask

    task automatic t_times();
        int n;
        logic [7:0] d;
        logic [3:0] ch;
        for (int dv = 0; dv < 2; dv++)
            for (int c = 0; c < 8; c++)
            begin
                ch = 4'(dv * 8 + c);
                div_opt <= dv[0];
                run_conv(ch, c[2:0], n);
                chk("cycles", 12'(cyc_of(dv[0], c[2:0])), 12'(n));
                chk("end", 12'h001, {10'h000, busy, eoc});
                rd(8'h98, d);
                chk("low", {lev[ch][1:0], 2'b10}, d[7:4]);
                rd(8'h9C, d);
                chk("high", lev[ch][9:2], d);
                rd(8'h98, d);
                chk("eoc_clr", 1'b0, d[5]);
                rd(8'h38, d);
                chk("c1_back", {4'b0010, ch}, d);
            end
        $display("timing test done");
    endtask

    task automatic t_repeat();
        int n;
        logic [7:0] d;
        logic [7:0] old;
        div_opt <= 1'b0;
        wr(8'h3C, 8'h10);
        wr(8'h38, 8'hE3);
        wait_irq(n);
        @(posedge ref_clk);
        wait_irq(n);
        chk("rep_gap", 12'd38, 12'(n));
        rd(8'h9C, d);
        chk("rep_val", lev[3][9:2], d);
        old = lev[3][9:2];
        lev[3] = ~lev[3];
        repeat (12) @(posedge ref_clk);
        wr(8'h38, 8'h03);
        n = 0;
        repeat (100)
        begin
            @(posedge ref_clk);
            if (irq === 1'b1)
                n++;
        end
        chk("abort", 12'h000, {11'(n), busy});
        rd(8'h9C, d);
        chk("abort_keep", old, d);
        $display("repeat test done");
    endtask

    task automatic t_restart();
        int n;
        logic [7:0] d;
        logic [7:0] old;
        run_conv(4'h5, 3'b000, n);
        old = lev[5][9:2];
        lev[5] = 10'h155;
        wr(8'h38, 8'hA5);
        chk("re_eoc", 1'b0, eoc);
        rd(8'h9C, d);
        chk("re_keep", old, d);
        wait_irq(n);
        rd(8'h9C, d);
        chk("re_new", 8'h55, d);
        $display("restart test done");
    endtask

    task automatic t_standby();
        logic [7:0] d;
        wr(8'h3C, 8'h30);
        @(posedge ref_clk);
        chk("ladder_on", 1'b1, analog_o.ladder_connect);
        wr(8'h3C, 8'h1C);
        @(posedge ref_clk);
        chk("ladder_off", 1'b0, analog_o.ladder_connect);
        wr(8'h38, 8'hB2);
        @(posedge ref_clk);
        chk("in_dis", 1'b1, analog_o.analog_input_disable);
        repeat (20) @(posedge ref_clk);
        standby_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("sb_flags", 12'h000, {10'h000, busy, eoc});
        wr(8'h3C, 8'h3E);
        standby_req <= 1'b0;
        @(posedge ref_clk);
        rd(8'h3C, d);
        chk("sb_c2", 8'h10, d & 8'h3F);
        rd(8'h38, d);
        chk("sb_c1", 8'h10, d);
        $display("standby test done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        standby_req = 1'b0;
        div_opt = 1'b0;
        wb_req = '0;
        for (int i = 0; i < 16; i++)
            lev[i] = 10'h3FF - 10'(i * 61);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_times();
        t_repeat();
        t_restart();
        t_standby();
        test_done();
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end
endmodule
